// ===== core/dcc_cal_seq.sv
// Purpose: Power-on sync and calibration, host-started calibration, done flags
// Assumes: adc_cal_done carries one pulse per channel when its ADC finishes
// Notes:   A new request while calibration runs is ignored
`timescale 1ns/1ps
`include "dcc_defs.svh"
module dcc_cal_seq
  import dcc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  input  wire logic        cal_req,
  input  wire logic        sync_cmd,
  input  wire dcc_chmask_t adc_cal_done,
  output dcc_chmask_t      cal_ok,
  output logic             adc_sync_pulse,
  output logic             adc_cal_start_pulse
);
  import dcc_pkg::*;

  dcc_cal_s cal_r;
  dcc_cal_s cal_nxt;

  always_comb begin
    cal_nxt             = cal_r;
    cal_nxt.sync_pulse  = sync_cmd;
    cal_nxt.start_pulse = 1'b0;
    cal_nxt.req_prev    = cal_req;
    case (cal_r.state)
      CAL_POR_SYNC: begin
        cal_nxt.sync_pulse = 1'b1;
        cal_nxt.state      = CAL_POR_START;
      end
      CAL_POR_START: begin
        cal_nxt.start_pulse = 1'b1;
        cal_nxt.cal_ok      = '0;
        cal_nxt.state       = CAL_RUN;
      end
      CAL_RUN: begin
        if (&cal_r.cal_ok) begin
          cal_nxt.state = CAL_IDLE;
        end
      end
      CAL_IDLE: begin
        // Edge, not level, so a bit left high does not loop
        if (cal_req && !cal_r.req_prev) begin
          cal_nxt.start_pulse = 1'b1;
          cal_nxt.cal_ok      = '0;
          cal_nxt.state       = CAL_RUN;
        end
      end
      default: begin
        cal_nxt.state = CAL_IDLE;
      end
    endcase
    // Completion set beats the start clear in the same cycle
    cal_nxt.cal_ok = cal_nxt.cal_ok | adc_cal_done;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      cal_r <= '{state: CAL_POR_SYNC, req_prev: 1'b0, cal_ok: '0, sync_pulse: 1'b0, start_pulse: 1'b0};
    end else begin
      cal_r <= cal_nxt;
    end
  end

  assign cal_ok              = cal_r.cal_ok;
  assign adc_sync_pulse      = cal_r.sync_pulse;
  assign adc_cal_start_pulse = cal_r.start_pulse;

endmodule : dcc_cal_seq

// ===== core/dcc_chan_offset.sv
// Purpose: Holds one channel's DC offset converter code
// Assumes: Load strobes are one-cycle pulses in the core_clk domain
// Notes:   A soft clear restores the reset code and reloads the converter
`timescale 1ns/1ps
`include "dcc_defs.svh"
module dcc_chan_offset
  import dcc_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  rst_b,
  input  wire logic                  soft_clr,
  input  wire logic                  load_en,
  input  wire logic [`DCC_DAC_W-1:0] load_val,
  output logic      [`DCC_DAC_W-1:0] dac_value,
  output logic                       dac_load
);
  import dcc_pkg::*;

  dcc_chan_s chan_r;
  dcc_chan_s chan_nxt;

  always_comb begin
    chan_nxt      = chan_r;
    chan_nxt.load = load_en | soft_clr;
    if (load_en) begin
      chan_nxt.value = load_val;
    end
    if (soft_clr) begin
      chan_nxt.value = `DCC_DAC_RST;
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_r <= '{value: `DCC_DAC_RST, load: 1'b0};
    end else begin
      chan_r <= chan_nxt;
    end
  end

  assign dac_value = chan_r.value;
  assign dac_load  = chan_r.load;

endmodule : dcc_chan_offset

// ===== core/dcc_defs.svh
// Purpose: Constants of the digitizer clock and ADC calibration control block
// Assumes: Included by the package and by every design file of the block
// Notes:   Offsets are byte addresses on a 16-bit AXI4-Lite address
`ifndef DCC_DEFS_SVH
`define DCC_DEFS_SVH

`define DCC_ADDR_W          16
`define DCC_DATA_W          32
`define DCC_N_CHAN          4
`define DCC_DAC_W           16
`define DCC_TEMP_W          8

`define DCC_ADDR_BOARD_CFG  16'h8000
`define DCC_ADDR_OFS_BCAST  16'h8098
`define DCC_ADDR_CAL_CTRL   16'h809c
`define DCC_ADDR_ACQ_CTRL   16'h8100
`define DCC_ADDR_SYNC_CMD   16'h813c
`define DCC_ADDR_RESET_CMD  16'hef24
`define DCC_CHAN_PAGE       4'h1
`define DCC_CHAN_OFS_LO     8'h98
`define DCC_CHAN_STAT_LO    8'h88
`define DCC_CHAN_TEMP_LO    8'ha8

`define DCC_DES_BIT         12
`define DCC_CLK_SRC_BIT     6
`define DCC_CAL_REQ_BIT     1
`define DCC_CAL_OK_BIT      6

`define DCC_BOARD_CFG_RST   32'h0000_0000
`define DCC_ACQ_CTRL_RST    32'h0000_0000
`define DCC_CAL_CTRL_RST    32'h0000_0000
`define DCC_DAC_RST         16'h0000

`define DCC_TRG_CLK_RATIO   4'h8
`define DCC_UNCERT_NORM     5'h08
`define DCC_UNCERT_DES      5'h10
`define DCC_EVEN_CH_MASK    4'h5
`define DCC_ALL_CH_MASK     4'hf
`define DCC_RESP_OKAY       2'h0
`define DCC_RESP_SLVERR     2'h2

`endif

// ===== core/dcc_pkg.sv
// Purpose: Types of the digitizer clock and ADC calibration control block
// Assumes: dcc_defs.svh supplies the numeric constants
// Notes:   Each module keeps its whole state in one struct from here
`include "dcc_defs.svh"
package dcc_pkg;

  typedef logic [`DCC_N_CHAN-1:0][`DCC_DAC_W-1:0]  dcc_dac_vec_t;
  typedef logic [`DCC_N_CHAN-1:0][`DCC_TEMP_W-1:0] dcc_temp_vec_t;
  typedef logic [`DCC_N_CHAN-1:0]                  dcc_chmask_t;

  typedef enum logic [1:0] {CAL_POR_SYNC, CAL_POR_START, CAL_RUN, CAL_IDLE} dcc_cal_state_e;

  typedef struct packed {
    dcc_cal_state_e state;
    logic           req_prev;
    dcc_chmask_t    cal_ok;
    logic           sync_pulse;
    logic           start_pulse;
  } dcc_cal_s;

  typedef struct packed {
    logic [`DCC_DAC_W-1:0] value;
    logic                  load;
  } dcc_chan_s;

  typedef struct packed {
    logic                   awready;
    logic                   wready;
    logic                   aw_got;
    logic                   w_got;
    logic [`DCC_ADDR_W-1:0] awaddr;
    logic [`DCC_DATA_W-1:0] wdata;
    logic [3:0]             wstrb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   arready;
    logic                   ar_got;
    logic [`DCC_ADDR_W-1:0] araddr;
    logic                   rvalid;
    logic [`DCC_DATA_W-1:0] rdata;
    logic [1:0]             rresp;
    logic [`DCC_DATA_W-1:0] board_cfg;
    logic [`DCC_DATA_W-1:0] acq_ctrl;
    logic [`DCC_DATA_W-1:0] cal_ctrl;
    logic                   board_reset_pulse;
    logic                   des_mode_en;
    logic                   ref_clk_sel_ext;
    dcc_chmask_t            chan_acq_en;
    logic [4:0]             trg_uncert_samples;
    logic [3:0]             trg_clk_ratio;
    logic                   pll_default_cfg;
  } dcc_top_s;

endpackage : dcc_pkg

// ===== core/dcc_top.sv
// Purpose: Reference clock selection, sampling mode, DC offsets and ADC calibration control
// Assumes: core_clk is the fixed local oscillator domain; AXI4-Lite register access
// Notes:   Clock chip, ADCs and converters sit outside; this block drives their controls
// Notes on behaviour
// - Channel offset write loads only that channel's DC offset converter.
// - Broadcast offset write loads the same value into every channel together.
// - Host access logic runs in the fixed local oscillator domain.
// - Sampling, trigger and acquisition clocks derive from the selected reference.
// - Acquisition control bit 6 selects internal or external reference clock.
// - After reset the reference is the internal local oscillator clock.
// - External mode takes the reference from the external clock input.
// - Default clock chip setup locks to a 50 MHz external reference.
// - Trigger logic clock is one eighth of the sampling clock.
// - Trigger uncertainty is eight samples, sixteen in dual-edge mode.
// - Board configuration bit 12 enables dual-edge sampling.
// - Dual-edge mode acquires on even channels only.
// - ADC self-calibration runs once at power-on without host command.
// - Host writes calibration bit 1 low then high; all channels start.
// - Status bit 6 clears at calibration start, sets at completion; host polls.
// - Each channel's ADC temperature is readable in its own register.
// - Any reset register write resets the board; wait before calibrating.
// - Any sync register write syncs the ADCs; also done at power-on.
`timescale 1ns/1ps
`include "dcc_defs.svh"
module dcc_top
  import dcc_pkg::*;
(
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [`DCC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]             s_axi_awprot,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  input  wire logic [`DCC_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  output logic      [1:0]             s_axi_bresp,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  input  wire logic [`DCC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]             s_axi_arprot,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic      [`DCC_DATA_W-1:0] s_axi_rdata,
  output logic      [1:0]             s_axi_rresp,
  input  wire dcc_pkg::dcc_chmask_t   adc_cal_done,
  input  wire dcc_pkg::dcc_temp_vec_t adc_temp,
  output logic                        ref_clk_sel_ext,
  output logic                        pll_default_cfg,
  output logic      [3:0]             trg_clk_ratio,
  output logic      [4:0]             trg_uncert_samples,
  output logic                        des_mode_en,
  output dcc_pkg::dcc_chmask_t        chan_acq_en,
  output dcc_pkg::dcc_dac_vec_t       dac_value,
  output dcc_pkg::dcc_chmask_t        dac_load,
  output logic                        adc_cal_start_pulse,
  output logic                        adc_sync_pulse,
  output logic                        board_reset_pulse
);
  import dcc_pkg::*;

  dcc_top_s    top_r;
  dcc_top_s    top_nxt;
  dcc_chmask_t chan_load;
  dcc_chmask_t cal_ok;
  logic        wr_go;
  logic        sync_cmd;
  logic        soft_clr;

  // Byte-lane merge for read-write registers
  function automatic logic [`DCC_DATA_W-1:0] dcc_merge(
    input logic [`DCC_DATA_W-1:0] old_val,
    input logic [`DCC_DATA_W-1:0] new_val,
    input logic [3:0]             strb
  );
    logic [`DCC_DATA_W-1:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : dcc_merge

  // Hit on a per-channel register: page 1, channel nibble, low byte
  function automatic logic dcc_chan_hit(
    input logic [`DCC_ADDR_W-1:0] addr,
    input logic [7:0]             lo
  );
    logic hit;
    hit = (addr[15:12] == `DCC_CHAN_PAGE) && (addr[11:10] == 2'h0) && (addr[7:0] == lo);
    return hit;
  endfunction : dcc_chan_hit

  // Writable addresses; status and temperature registers are refused
  function automatic logic dcc_wr_known(
    input logic [`DCC_ADDR_W-1:0] addr
  );
    logic known;
    case (addr)
      `DCC_ADDR_BOARD_CFG, `DCC_ADDR_OFS_BCAST, `DCC_ADDR_CAL_CTRL,
      `DCC_ADDR_ACQ_CTRL, `DCC_ADDR_SYNC_CMD, `DCC_ADDR_RESET_CMD: begin
        known = 1'b1;
      end
      default: begin
        known = dcc_chan_hit(addr, `DCC_CHAN_OFS_LO);
      end
    endcase
    return known;
  endfunction : dcc_wr_known

  always_comb begin
    logic [1:0] rch;
    rch     = 2'h0;
    top_nxt = top_r;
    // Both halves of a write present: commit and answer together on the next edge
    wr_go     = top_r.aw_got & top_r.w_got;
    sync_cmd  = 1'b0;
    soft_clr  = 1'b0;
    chan_load = '0;
    top_nxt.board_reset_pulse = 1'b0;

    if (s_axi_awvalid && top_r.awready) begin
      top_nxt.aw_got = 1'b1;
      top_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && top_r.wready) begin
      top_nxt.w_got = 1'b1;
      top_nxt.wdata = s_axi_wdata;
      top_nxt.wstrb = s_axi_wstrb;
    end
    if (top_r.bvalid && s_axi_bready) begin
      top_nxt.bvalid = 1'b0;
    end

    if (wr_go) begin
      top_nxt.aw_got = 1'b0;
      top_nxt.w_got  = 1'b0;
      top_nxt.bvalid = 1'b1;
      top_nxt.bresp  = dcc_wr_known(top_r.awaddr) ? `DCC_RESP_OKAY : `DCC_RESP_SLVERR;
      case (top_r.awaddr)
        `DCC_ADDR_BOARD_CFG: begin
          top_nxt.board_cfg = dcc_merge(top_r.board_cfg, top_r.wdata, top_r.wstrb);
        end
        `DCC_ADDR_ACQ_CTRL: begin
          top_nxt.acq_ctrl = dcc_merge(top_r.acq_ctrl, top_r.wdata, top_r.wstrb);
        end
        `DCC_ADDR_CAL_CTRL: begin
          top_nxt.cal_ctrl = dcc_merge(top_r.cal_ctrl, top_r.wdata, top_r.wstrb);
        end
        `DCC_ADDR_OFS_BCAST: begin
          chan_load = `DCC_ALL_CH_MASK;
        end
        `DCC_ADDR_SYNC_CMD: begin
          sync_cmd = 1'b1;
        end
        `DCC_ADDR_RESET_CMD: begin
          // Any data resets; the bus itself keeps running to finish the answer
          soft_clr                  = 1'b1;
          top_nxt.board_reset_pulse = 1'b1;
          top_nxt.board_cfg         = `DCC_BOARD_CFG_RST;
          top_nxt.acq_ctrl          = `DCC_ACQ_CTRL_RST;
          top_nxt.cal_ctrl          = `DCC_CAL_CTRL_RST;
        end
        default: begin
          if (dcc_chan_hit(top_r.awaddr, `DCC_CHAN_OFS_LO)) begin
            chan_load[top_r.awaddr[9:8]] = 1'b1;
          end
        end
      endcase
    end

    if (s_axi_arvalid && top_r.arready) begin
      top_nxt.ar_got = 1'b1;
      top_nxt.araddr = s_axi_araddr;
    end
    if (top_r.rvalid && s_axi_rready) begin
      top_nxt.rvalid = 1'b0;
    end
    if (top_r.ar_got) begin
      top_nxt.ar_got = 1'b0;
      top_nxt.rvalid = 1'b1;
      top_nxt.rdata  = '0;
      top_nxt.rresp  = `DCC_RESP_OKAY;
      rch            = top_r.araddr[9:8];
      case (top_r.araddr)
        `DCC_ADDR_BOARD_CFG: begin
          top_nxt.rdata = top_r.board_cfg;
        end
        `DCC_ADDR_ACQ_CTRL: begin
          top_nxt.rdata = top_r.acq_ctrl;
        end
        `DCC_ADDR_CAL_CTRL: begin
          top_nxt.rdata = top_r.cal_ctrl;
        end
        // Command registers are write-only and read as zero
        `DCC_ADDR_OFS_BCAST, `DCC_ADDR_SYNC_CMD, `DCC_ADDR_RESET_CMD: begin
          top_nxt.rdata = '0;
        end
        default: begin
          if (dcc_chan_hit(top_r.araddr, `DCC_CHAN_OFS_LO)) begin
            top_nxt.rdata[`DCC_DAC_W-1:0] = dac_value[rch];
          end else if (dcc_chan_hit(top_r.araddr, `DCC_CHAN_STAT_LO)) begin
            top_nxt.rdata[`DCC_CAL_OK_BIT] = cal_ok[rch];
          end else if (dcc_chan_hit(top_r.araddr, `DCC_CHAN_TEMP_LO)) begin
            top_nxt.rdata[`DCC_TEMP_W-1:0] = adc_temp[rch];
          end else begin
            top_nxt.rresp = `DCC_RESP_SLVERR;
          end
        end
      endcase
    end

    // Ready drops while a request is held or its answer is still pending
    top_nxt.awready = ~top_nxt.aw_got & ~top_nxt.bvalid;
    top_nxt.wready  = ~top_nxt.w_got & ~top_nxt.bvalid;
    top_nxt.arready = ~top_nxt.ar_got & ~top_nxt.rvalid;

    // Clock chip gets the select; all sampling side clocks follow from it
    top_nxt.ref_clk_sel_ext = top_nxt.acq_ctrl[`DCC_CLK_SRC_BIT];
    // Divider setup is never touched; 50 MHz in either source locks as is
    top_nxt.pll_default_cfg = 1'b1;
    top_nxt.trg_clk_ratio   = `DCC_TRG_CLK_RATIO;
    top_nxt.des_mode_en     = top_nxt.board_cfg[`DCC_DES_BIT];
    top_nxt.chan_acq_en     = top_nxt.des_mode_en ? `DCC_EVEN_CH_MASK : `DCC_ALL_CH_MASK;
    top_nxt.trg_uncert_samples = top_nxt.des_mode_en ? `DCC_UNCERT_DES : `DCC_UNCERT_NORM;
  end

  // The whole register file lives on core_clk, the local oscillator domain
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      top_r                    <= '0;
      top_r.board_cfg          <= `DCC_BOARD_CFG_RST;
      top_r.acq_ctrl           <= `DCC_ACQ_CTRL_RST;
      top_r.cal_ctrl           <= `DCC_CAL_CTRL_RST;
      top_r.pll_default_cfg    <= 1'b1;
      top_r.trg_clk_ratio      <= `DCC_TRG_CLK_RATIO;
      top_r.chan_acq_en        <= `DCC_ALL_CH_MASK;
      top_r.trg_uncert_samples <= `DCC_UNCERT_NORM;
    end else begin
      top_r <= top_nxt;
    end
  end

  for (genvar ch = 0; ch < `DCC_N_CHAN; ch++) begin : g_chan
    dcc_chan_offset u_ofs (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .soft_clr  (soft_clr),
      .load_en   (chan_load[ch]),
      .load_val  (top_r.wdata[`DCC_DAC_W-1:0]),
      .dac_value (dac_value[ch]),
      .dac_load  (dac_load[ch])
    );
  end

  dcc_cal_seq u_cal (
    .core_clk            (core_clk),
    .rst_b               (rst_b),
    .cal_req             (top_r.cal_ctrl[`DCC_CAL_REQ_BIT]),
    .sync_cmd            (sync_cmd),
    .adc_cal_done        (adc_cal_done),
    .cal_ok              (cal_ok),
    .adc_sync_pulse      (adc_sync_pulse),
    .adc_cal_start_pulse (adc_cal_start_pulse)
  );

  assign s_axi_awready      = top_r.awready;
  assign s_axi_wready       = top_r.wready;
  assign s_axi_bvalid       = top_r.bvalid;
  assign s_axi_bresp        = top_r.bresp;
  assign s_axi_arready      = top_r.arready;
  assign s_axi_rvalid       = top_r.rvalid;
  assign s_axi_rdata        = top_r.rdata;
  assign s_axi_rresp        = top_r.rresp;
  assign ref_clk_sel_ext    = top_r.ref_clk_sel_ext;
  assign pll_default_cfg    = top_r.pll_default_cfg;
  assign trg_clk_ratio      = top_r.trg_clk_ratio;
  assign trg_uncert_samples = top_r.trg_uncert_samples;
  assign des_mode_en        = top_r.des_mode_en;
  assign chan_acq_en        = top_r.chan_acq_en;
  assign board_reset_pulse  = top_r.board_reset_pulse;

endmodule : dcc_top

// ===== dv/dcc_adc_model.sv
// Purpose: ADC side: calibration done pulses and temperatures
// Assumes: Start is a one-cycle pulse
// Notes:   Channels finish staggered so flags set one by one
`timescale 1ns/1ps
module dcc_adc_model
  import dcc_pkg::*;
#(
  parameter int CAL_CYC = 40
)(
  input  wire logic             core_clk,
  input  wire logic             rst_b,
  input  wire logic             adc_cal_start_pulse,
  output dcc_pkg::dcc_chmask_t  adc_cal_done,
  output dcc_pkg::dcc_temp_vec_t adc_temp
);
  int cnt_r;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) cnt_r <= -1;
    else if (adc_cal_start_pulse) cnt_r <= 0;
    else if (cnt_r >= 0) cnt_r <= (cnt_r == CAL_CYC + 10) ? -1 : cnt_r + 1;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      adc_cal_done[i] = (cnt_r == CAL_CYC + 3 * i);
      adc_temp[i]     = 8'h20 + 8'(i);
    end
  end
endmodule : dcc_adc_model

// ===== dv/dcc_top_asserts.sv
// Purpose: Port-level checks of the clock and calibration control block
// Assumes: Bound to dcc_top; one core_clk domain
// Notes:   Register effects are tied to the edge where bvalid rises
`timescale 1ns/1ps
`include "dcc_defs.svh"
module dcc_top_asserts
  import dcc_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 rst_b,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 ref_clk_sel_ext,
  input wire logic [4:0]           trg_uncert_samples,
  input wire logic                 des_mode_en,
  input wire dcc_pkg::dcc_chmask_t chan_acq_en,
  input wire dcc_pkg::dcc_chmask_t dac_load,
  input wire logic                 adc_cal_start_pulse,
  input wire logic                 adc_sync_pulse
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_CLK_SEL_CAUSE: assert property ($changed(ref_clk_sel_ext) |-> $rose(s_axi_bvalid))
    else $error("clock source moved without a write");
  AST_DES_CAUSE: assert property ($changed(des_mode_en) |-> $rose(s_axi_bvalid))
    else $error("dual-edge mode moved without a write");
  AST_UNCERT: assert property (trg_uncert_samples == (des_mode_en ? `DCC_UNCERT_DES : `DCC_UNCERT_NORM))
    else $error("trigger uncertainty wrong for mode");
  AST_EVEN_ONLY: assert property (chan_acq_en == (des_mode_en ? 4'h5 : 4'hf))
    else $error("channel enables wrong for mode");
  AST_DAC_AFTER_RESP: assert property (|dac_load |-> $rose(s_axi_bvalid))
    else $error("converter load not at the commit edge");
  AST_START_PULSE: assert property (adc_cal_start_pulse |=> !adc_cal_start_pulse)
    else $error("calibration start wider than one cycle");
  AST_SYNC_PULSE: assert property (adc_sync_pulse |=> !adc_sync_pulse)
    else $error("sync wider than one cycle");
endmodule : dcc_top_asserts

bind dcc_top dcc_top_asserts u_chk (.core_clk, .rst_b, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
  .ref_clk_sel_ext, .trg_uncert_samples, .des_mode_en, .chan_acq_en, .dac_load, .adc_cal_start_pulse,
  .adc_sync_pulse);

// ===== dv/tb_dcc_top.sv
// Purpose: Register-level test of the clock and calibration control block
// Assumes: AXI4-Lite master tasks; ADC model answers calibration starts
// Notes:   Calibration shortened to tens of cycles in the model
`timescale 1ns/1ps
module tb_dcc_top;
  import dcc_pkg::*;
  logic core_clk = 1'b0, rst_b = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [15:0] s_axi_awaddr = 16'h0, s_axi_araddr = 16'h0;
  logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf, trg_clk_ratio;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [4:0]  trg_uncert_samples;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic ref_clk_sel_ext, pll_default_cfg, des_mode_en, adc_cal_start_pulse, adc_sync_pulse, board_reset_pulse;
  dcc_chmask_t   adc_cal_done, chan_acq_en, dac_load;
  dcc_temp_vec_t adc_temp;
  dcc_dac_vec_t  dac_value;
  int n_fail = 0, comparisons = 0, n_start = 0, n_sync = 0, n_brst = 0, cyc = 0;

  dcc_top uut (.*);
  dcc_adc_model u_adc (.core_clk, .rst_b, .adc_cal_start_pulse, .adc_cal_done, .adc_temp);

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // Pulse counters; reset gate keeps them clear of early unknowns
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (rst_b && adc_cal_start_pulse) n_start <= n_start + 1;
    if (rst_b && adc_sync_pulse) n_sync <= n_sync + 1;
    if (rst_b && board_reset_pulse) n_brst <= n_brst + 1;
    if (cyc == 5000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // bw > 0 holds bready low for that many cycles of a pending response
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0, input int bw = 0);
    @(posedge core_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= (bw == 0);
    do begin
      @(posedge core_clk);
      if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
      if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) begin
        bw--;
        if (bw == 0) s_axi_bready <= 1'b1;
      end
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : wr

  task automatic rdm(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er = 2'h0);
    @(posedge core_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rd = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    if (m != 32'h0) chk(rd & m, e);
  endtask : rdm

  initial begin
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (100) @(posedge core_clk);
    chk(n_sync, 1);
    chk(n_start, 1);
    chk({27'h0, trg_clk_ratio, pll_default_cfg}, 32'h11);
    for (int n = 0; n < 4; n++) begin
      rdm(16'h1088 + 16'(n << 8), 32'h40, 32'h40);
      rdm(16'h10a8 + 16'(n << 8), 32'hff, 32'h20 + n);
    end
    rdm(16'h8100, 32'h40, 32'h0);
    chk({31'h0, ref_clk_sel_ext}, 32'h0);
    wr(16'h8100, 32'h40);
    chk({31'h0, ref_clk_sel_ext}, 32'h1);
    rdm(16'h8100, 32'h40, 32'h40);
    wr(16'h8000, 32'h1000);
    chk({27'h0, des_mode_en, chan_acq_en}, 32'h15);
    chk({27'h0, trg_uncert_samples}, 32'h10);
    for (int n = 0; n < 4; n++) begin
      wr(16'h1098 + 16'(n << 8), 32'h1100 * (n + 1));
      @(posedge core_clk);
      chk(dac_value[n], 32'h1100 * (n + 1));
    end
    for (int n = 0; n < 4; n++) begin
      chk(dac_value[n], 32'h1100 * (n + 1));
      rdm(16'h1098 + 16'(n << 8), 32'hffff, 32'h1100 * (n + 1));
    end
    wr(16'h8098, 32'hbeef);
    @(posedge core_clk);
    for (int n = 0; n < 4; n++) chk(dac_value[n], 32'hbeef);
    wr(16'h809c, 32'h0);
    wr(16'h809c, 32'h2);
    rdm(16'h1188, 32'h40, 32'h0);
    for (int k = 0; k < 50 && !rd[6]; k++) rdm(16'h1388, 32'h0, 32'h0);
    chk({31'h0, rd[6]}, 32'h1);
    chk(n_start, 2);
    // Rewriting a held-high request must not start again
    wr(16'h809c, 32'h2);
    repeat (5) @(posedge core_clk);
    chk(n_start, 2);
    wr(16'h809c, 32'h0);
    rdm(16'h809c, 32'h2, 32'h0);
    wr(16'h813c, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(n_sync, 2);
    // A host sync needs a fresh calibration
    wr(16'h809c, 32'h2);
    rd = 32'h0;
    for (int k = 0; k < 50 && !rd[6]; k++) rdm(16'h1388, 32'h0, 32'h0);
    chk({31'h0, rd[6]}, 32'h1);
    chk(n_start, 3);
    wr(16'h809c, 32'h0);
    wr(16'hef24, 32'h5);
    repeat (2) @(posedge core_clk);
    chk(n_brst, 1);
    chk({30'h0, ref_clk_sel_ext, des_mode_en}, 32'h0);
    chk(dac_value[2], 32'h0);
    // Late bready: response must stand until taken
    wr(16'h4000, 32'h1, 2'h2, 3);
    wr(16'h1088, 32'h0, 2'h2);
    rdm(16'h4000, 32'hffffffff, 32'h0, 2'h2);
    conclude();
  end
endmodule : tb_dcc_top
